// >>> logic/dlb_data_line_buffer_unit.sv
// Data line buffer unit: four 128-bit lines caching CPU data reads and
// gathering writes. Assumes the CPU holds a request until CPU_DONE and the
// memory port answers one beat per request.
`timescale 1ns/1ps
// How it works
// R1: Each line holds 128 bits as four words, for reads and gathered writes.
// R2: Only data accesses inside the shared memory window use the lines.
// R3: Instruction fetches and out-of-window accesses bypass the lines entirely.
// R4: Each line carries a four-value state tag steering all decisions.
// R5: A modified line is written back before it is reused.
// R6: A write miss allocates a write line and records written bytes.
// R7: Reading a write line fetches memory, merges unwritten bytes, becomes modified.
// R8: A write line whose bytes are all written becomes modified.
// R9: A write hitting a shared line updates it and makes it modified.
// R10: A read miss fetches the whole line into a shared line.
// R11: Allocate invalid lines first, else oldest line, shared preferred.
// R12: Dirty lines may be flushed; flushed modified lines that are not aged become shared.
// R13: Flush aggressiveness caps dirty lines at two or three.
// R14: Each line has an enable; disabled lines are never allocated.
// R15: A gray aging counter steps every N cycles, N from 1 to 255.
// R16: Every allocation or use stamps the line with the aging counter.
// R17: A line self-flushes two aging steps after its stamp.
// R18: Aged shared lines invalidate, aged dirty lines write back, freeing them.
// R19: A line's recency counter clears on its use, grows on others' use.
// R20: Sleep requests and the sideband flush input flush all lines.
// R21: Software flushes before deep sleep and when coherency matters.
// R22: Software enables one line and keeps aging at two steps.
// R23: Barrier is flush then invalidate, leaving every line invalid.
// R24: Write-line write-back drives strobes from the byte enables.
module dlb_data_line_buffer_unit
  import dlb_pkg::*;
(
  input  wire logic               CLOCK,
  input  wire logic               SYS_RST,
  input  wire dlb_cfg_t           CFG,
  input  wire logic               SLEEP_REQ,
  input  wire logic               FLUSH_REQ,
  input  wire logic               INVAL_REQ,
  input  wire dlb_cpu_req_t       CPU_REQ,
  output logic                    CPU_BYPASS,
  output logic                    CPU_DONE,
  output logic [WORD_W-1:0]       CPU_RDATA,
  output dlb_rd_req_t             MEM_RD,
  input  wire logic               MEM_RD_READY,
  input  wire logic               MEM_RD_VALID,
  input  wire logic [LINE_W-1:0]  MEM_RD_DATA,
  output dlb_wr_req_t             MEM_WR,
  input  wire logic               MEM_WR_READY,
  input  wire logic               MEM_WR_RESP,
  output logic                    BUSY,
  output logic [2:0]              DIRTY_LINES
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (SYS_RST);

  function automatic logic [LINE_W-1:0] put_word(input logic [LINE_W-1:0] d, // see R1
      input logic [1:0] w, input logic [WORD_W-1:0] v, input logic [3:0] s);
    logic [LINE_W-1:0] r;
    r = d;
    for (int b = 0; b < WORD_BY; b++) begin
      if (s[b]) r[w*WORD_W+b*BYTE_W +: BYTE_W] = v[b*BYTE_W +: BYTE_W];
    end
    return r;
  endfunction

  function automatic logic [BE_W-1:0] put_be(input logic [BE_W-1:0] be,
      input logic [1:0] w, input logic [3:0] s);
    return be | (BE_W'(s) << {w, 2'b00});
  endfunction

  // Fill keeps the bytes the CPU already wrote
  function automatic logic [LINE_W-1:0] fill_merge(input logic [LINE_W-1:0] old,
      input logic [BE_W-1:0] be, input logic [LINE_W-1:0] mem);
    logic [LINE_W-1:0] r;
    r = mem;
    for (int b = 0; b < BE_W; b++) begin
      if (be[b]) r[b*BYTE_W +: BYTE_W] = old[b*BYTE_W +: BYTE_W];
    end
    return r;
  endfunction

  function automatic logic [1:0] g2b(input logic [1:0] g);
    return {g[1], g[1] ^ g[0]};
  endfunction

  function automatic logic is_dirty(input dlb_line_state_tag_t s); // see R4
    return (s == LS_WRITE) || (s == LS_MODIFIED);
  endfunction

  // Aging counter
  logic [7:0] age_cnt_q, age_cnt_d;
  logic [1:0] age_bin_q, age_bin_d;
  logic [1:0] age_gray;

  always_comb begin
    age_cnt_d = 8'(age_cnt_q + DIV_ONE);
    age_bin_d = age_bin_q;
    if (age_cnt_d >= CFG.age_div) begin // see R15
      age_cnt_d = '0;
      age_bin_d = 2'(age_bin_q + AGE_ONE);
    end
  end

  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      age_cnt_q <= '0;
      age_bin_q <= '0;
    end else begin
      age_cnt_q <= age_cnt_d;
      age_bin_q <= age_bin_d;
    end
  end

  assign age_gray = age_bin_q ^ (age_bin_q >> 1);

  // Line lookup
  dlb_line_t            lines_q [NUM_LINES];
  dlb_line_t            lines_d [NUM_LINES];
  dlb_fsm_t             state_q, state_d;
  logic [IDX_W-1:0]     sel_q, sel_d;
  dlb_line_state_tag_t  wb_next_q, wb_next_d;
  dlb_rd_req_t          rd_q, rd_d;
  dlb_wr_req_t          wr_q, wr_d;
  logic                 done_q, done_d;
  logic [WORD_W-1:0]    rdata_q, rdata_d;
  logic                 flush_pend_q, flush_pend_d;
  logic                 inval_pend_q, inval_pend_d;
  logic                 in_win, cpu_take, hit, free_ok, fl_ok, fl_aged, wb_start;
  logic                 touch_en;
  logic [IDX_W-1:0]     hit_idx, free_idx, vic_idx, fl_idx, touch_idx;
  logic [2:0]           vic_score, dirty_cnt, dirty_lim;
  logic [NUM_LINES-1:0] aged;
  logic [TAG_W-1:0]     req_tag;
  logic [1:0]           req_w;

  assign req_tag  = CPU_REQ.addr[31:OFS_W];
  assign req_w    = CPU_REQ.addr[OFS_W-1:2];
  assign in_win   = (CPU_REQ.addr >= WIN_LO) && (CPU_REQ.addr <= WIN_HI); // see R2
  assign CPU_BYPASS = CPU_REQ.valid && (CPU_REQ.instr || !in_win); // see R3
  assign cpu_take = CPU_REQ.valid && !CPU_BYPASS && !done_q && (state_q == ST_IDLE);
  assign dirty_lim = CFG.flush_aggressiveness ? DIRTY_L1 : DIRTY_L0; // see R13

  always_comb begin
    hit = 1'b0; hit_idx = '0; free_ok = 1'b0; free_idx = '0;
    vic_idx = '0; vic_score = '0; fl_ok = 1'b0; fl_idx = '0; fl_aged = 1'b0;
    dirty_cnt = '0; aged = '0;
    for (int i = 0; i < NUM_LINES; i++) begin
      aged[i] = 2'(age_bin_q - g2b(lines_q[i].stamp)) >= AGE_STEPS; // see R17
      if (is_dirty(lines_q[i].st)) dirty_cnt = 3'(dirty_cnt + 3'h1);
      if (lines_q[i].st != LS_INVALID && lines_q[i].tag == req_tag) begin
        hit = 1'b1;
        hit_idx = IDX_W'(i);
      end
      if (CFG.line_en[i] && lines_q[i].st == LS_INVALID && !free_ok) begin // see R14
        free_ok = 1'b1;
        free_idx = IDX_W'(i);
      end
      // Shared first, then oldest: shared needs no write-back
      if (CFG.line_en[i] && {lines_q[i].st == LS_SHARED, lines_q[i].recency_counter} >= vic_score) begin
        vic_score = {lines_q[i].st == LS_SHARED, lines_q[i].recency_counter}; // see R11
        vic_idx = IDX_W'(i);
      end
      if (is_dirty(lines_q[i].st) && (flush_pend_q || aged[i]) && !fl_ok) begin
        fl_ok = 1'b1;
        fl_idx = IDX_W'(i);
        fl_aged = aged[i];
      end
    end
    if (!fl_ok && dirty_cnt > dirty_lim) begin
      for (int i = 0; i < NUM_LINES; i++) begin
        if (is_dirty(lines_q[i].st) && (!fl_ok || lines_q[i].recency_counter >= lines_q[fl_idx].recency_counter)) begin
          fl_ok = 1'b1;
          fl_idx = IDX_W'(i);
        end
      end
    end
  end

  // Main sequencer
  always_comb begin
    state_d = state_q; lines_d = lines_q; sel_d = sel_q; wb_next_d = wb_next_q;
    rd_d = rd_q; wr_d = wr_q; done_d = 1'b0; rdata_d = rdata_q;
    flush_pend_d = flush_pend_q; inval_pend_d = inval_pend_q;
    touch_en = 1'b0; touch_idx = hit_idx; wb_start = 1'b0;
    case (state_q)
      ST_IDLE: begin
        if (cpu_take && hit) begin
          touch_en = 1'b1; // see R16
          if (CPU_REQ.write) begin
            lines_d[hit_idx].data = put_word(lines_q[hit_idx].data, req_w,
                                             CPU_REQ.wdata, CPU_REQ.wstrb);
            if (lines_q[hit_idx].st == LS_SHARED) begin
              lines_d[hit_idx].st = LS_MODIFIED; // see R9
            end else if (lines_q[hit_idx].st == LS_WRITE) begin
              lines_d[hit_idx].be = put_be(lines_q[hit_idx].be, req_w, CPU_REQ.wstrb); // see R6
              if (&lines_d[hit_idx].be) lines_d[hit_idx].st = LS_MODIFIED; // see R8
            end
            done_d = 1'b1;
          end else if (lines_q[hit_idx].st == LS_WRITE) begin
            sel_d = hit_idx; // see R7
            rd_d = '{1'b1, {req_tag, OFS_W'(0)}};
            state_d = ST_RD;
          end else begin
            rdata_d = lines_q[hit_idx].data[req_w*WORD_W +: WORD_W]; // see R10
            done_d = 1'b1;
          end
        end else if (cpu_take && free_ok) begin
          touch_en = 1'b1;
          touch_idx = free_idx;
          lines_d[free_idx].tag = req_tag;
          if (CPU_REQ.write) begin
            lines_d[free_idx].st = LS_WRITE; // see R6
            lines_d[free_idx].be = put_be('0, req_w, CPU_REQ.wstrb);
            lines_d[free_idx].data = put_word(lines_q[free_idx].data, req_w,
                                              CPU_REQ.wdata, CPU_REQ.wstrb);
            done_d = 1'b1;
          end else begin
            sel_d = free_idx; // see R10
            rd_d = '{1'b1, {req_tag, OFS_W'(0)}};
            state_d = ST_RD;
          end
        end else if (cpu_take && CFG.line_en != '0) begin
          if (lines_q[vic_idx].st == LS_SHARED) begin
            lines_d[vic_idx].st = LS_INVALID; // see R11
          end else begin
            sel_d = vic_idx; // see R5
            wb_next_d = LS_INVALID;
            wb_start = 1'b1;
          end
        end else if (!cpu_take && inval_pend_q) begin
          for (int i = 0; i < NUM_LINES; i++) begin
            if (lines_q[i].st == LS_SHARED) lines_d[i].st = LS_INVALID; // see R23
          end
          inval_pend_d = 1'b0;
        end else if (!cpu_take) begin
          for (int i = 0; i < NUM_LINES; i++) begin
            if (lines_q[i].st == LS_SHARED && aged[i]) lines_d[i].st = LS_INVALID; // see R18
          end
          if (fl_ok) begin
            sel_d = fl_idx;
            // Flush keeps modified data readable; aging frees the line
            wb_next_d = (lines_q[fl_idx].st == LS_MODIFIED && !fl_aged) ?
                        LS_SHARED : LS_INVALID; // see R12
            wb_start = 1'b1;
          end else if (dirty_cnt == '0) begin
            flush_pend_d = 1'b0;
          end
        end
      end
      ST_WB: begin
        if (MEM_WR_READY) begin
          wr_d.valid = 1'b0;
          state_d = ST_WB_RESP;
        end
      end
      ST_WB_RESP: begin
        if (MEM_WR_RESP) begin
          lines_d[sel_q].st = wb_next_q;
          lines_d[sel_q].be = '0;
          state_d = ST_IDLE;
        end
      end
      ST_RD: begin
        if (MEM_RD_READY) begin
          rd_d.valid = 1'b0;
          state_d = ST_RD_RESP;
        end
      end
      ST_RD_RESP: begin
        if (MEM_RD_VALID) begin
          if (lines_q[sel_q].st == LS_WRITE) begin
            lines_d[sel_q].data = fill_merge(lines_q[sel_q].data, lines_q[sel_q].be,
                                             MEM_RD_DATA); // see R7
            lines_d[sel_q].st = LS_MODIFIED;
            lines_d[sel_q].be = '0;
          end else begin
            lines_d[sel_q].data = MEM_RD_DATA; // see R10
            lines_d[sel_q].st = LS_SHARED;
          end
          rdata_d = lines_d[sel_q].data[req_w*WORD_W +: WORD_W];
          done_d = 1'b1;
          state_d = ST_IDLE;
        end
      end
      default: state_d = ST_IDLE;
    endcase
    if (wb_start) begin
      // Write lines carry only the written bytes to memory
      wr_d = '{1'b1, {lines_q[sel_d].tag, OFS_W'(0)}, lines_q[sel_d].data,
               (lines_q[sel_d].st == LS_WRITE) ? lines_q[sel_d].be : '1}; // see R24
      state_d = ST_WB;
    end
    if (touch_en) begin
      for (int i = 0; i < NUM_LINES; i++) begin
        if (IDX_W'(i) == touch_idx) begin
          lines_d[i].recency_counter = '0; // see R19
          lines_d[i].stamp = age_gray; // see R16
        end else if (lines_q[i].recency_counter != LRU_MAX) begin
          lines_d[i].recency_counter = 2'(lines_q[i].recency_counter + 2'h1);
        end
      end
    end
    if (FLUSH_REQ || SLEEP_REQ) flush_pend_d = 1'b1; // see R20
    if (INVAL_REQ) inval_pend_d = 1'b1;
  end

  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      lines_q <= '{default: '0};
      state_q <= ST_IDLE;
      sel_q <= '0;
      wb_next_q <= LS_INVALID;
      rd_q <= '0;
      wr_q <= '0;
      done_q <= 1'b0;
      rdata_q <= '0;
      flush_pend_q <= 1'b0;
      inval_pend_q <= 1'b0;
    end else begin
      lines_q <= lines_d;
      state_q <= state_d;
      sel_q <= sel_d;
      wb_next_q <= wb_next_d;
      rd_q <= rd_d;
      wr_q <= wr_d;
      done_q <= done_d;
      rdata_q <= rdata_d;
      flush_pend_q <= flush_pend_d;
      inval_pend_q <= inval_pend_d;
    end
  end

  assign CPU_DONE = done_q;
  assign CPU_RDATA = rdata_q;
  assign MEM_RD = rd_q;
  assign MEM_WR = wr_q;
  assign BUSY = (state_q != ST_IDLE) || flush_pend_q || inval_pend_q;
  assign DIRTY_LINES = dirty_cnt;

  sequence fill_ends;
    state_q == ST_RD_RESP && MEM_RD_VALID;
  endsequence

  chk_bypass_quiet: assert property (CPU_BYPASS |=> !CPU_DONE) // see R3
    else $error("bypassed access answered");
  chk_window_only: assert property (CPU_DONE |-> $past(CPU_REQ.addr) >= WIN_LO) // see R2
    else $error("answer for address below window");
  chk_write_merge: assert property (fill_ends and lines_q[sel_q].st == LS_WRITE // see R7
    |=> lines_q[sel_q].st == LS_MODIFIED && CPU_DONE)
    else $error("filled write line not modified");
  chk_read_fill: assert property (fill_ends and lines_q[sel_q].st == LS_INVALID // see R10
    |=> lines_q[sel_q].st == LS_SHARED && lines_q[sel_q].data == $past(MEM_RD_DATA))
    else $error("read fill not shared");
  chk_wb_strobe: assert property (MEM_WR.valid && lines_q[sel_q].st == LS_WRITE // see R24
    |-> MEM_WR.strb == lines_q[sel_q].be)
    else $error("write strobes differ from byte enables");
  chk_dirty_cap: assert property (state_q == ST_IDLE && !cpu_take && !inval_pend_q // see R13
    && dirty_cnt > dirty_lim |=> state_q == ST_WB)
    else $error("dirty limit exceeded without flush");
  chk_gray_step: assert property ($changed(age_gray) // see R15
    |-> $onehot(age_gray ^ $past(age_gray)))
    else $error("aging counter not gray");
  chk_shared_write: assert property (cpu_take && hit && CPU_REQ.write // see R9
    && lines_q[hit_idx].st == LS_SHARED |=> lines_q[$past(hit_idx)].st == LS_MODIFIED)
    else $error("shared write hit not modified");
  chk_lru_clear: assert property (touch_en // see R19
    |=> lines_q[$past(touch_idx)].recency_counter == '0 && lines_q[$past(touch_idx)].stamp == $past(age_gray))
    else $error("use did not clear recency");

  for (genvar g = 0; g < NUM_LINES; g++) begin : g_line_chk
    chk_reuse_clean: assert property ($changed(lines_q[g].tag) // see R5
      |-> $past(lines_q[g].st) == LS_INVALID)
      else $error("line reused while holding data");
    chk_disabled_line: assert property (!CFG.line_en[g] && lines_q[g].st == LS_INVALID // see R14
      && $stable(CFG.line_en) |=> lines_q[g].st == LS_INVALID)
      else $error("disabled line allocated");
  end
endmodule

// >>> logic/dlb_pkg.sv
// Constants and carrier types for the data line buffer unit.
// Assumes one CPU clock domain and a single-beat 128-bit memory port.
package dlb_pkg;
  localparam int NUM_LINES = 4;
  localparam int IDX_W     = 2;
  localparam int BYTE_W    = 8;
  localparam int WORD_W    = 32;
  localparam int WORD_BY   = 4;
  localparam int LINE_W    = 128;
  localparam int BE_W      = 16;
  localparam int TAG_W     = 28;
  localparam int OFS_W     = 4;
  localparam logic [31:0] WIN_LO    = 32'h1006_0000;
  localparam logic [31:0] WIN_HI    = 32'h1FFF_FFFF;
  localparam logic [1:0]  AGE_STEPS = 2'h2;
  localparam logic [1:0]  AGE_ONE   = 2'h1;
  localparam logic [7:0]  DIV_ONE   = 8'h01;
  localparam logic [2:0]  DIRTY_L0  = 3'h2;
  localparam logic [2:0]  DIRTY_L1  = 3'h3;
  localparam logic [1:0]  LRU_MAX   = 2'h3;

  typedef enum logic [1:0] {LS_INVALID, LS_SHARED, LS_WRITE, LS_MODIFIED} dlb_line_state_tag_t;
  typedef enum logic [2:0] {ST_IDLE, ST_WB, ST_WB_RESP, ST_RD, ST_RD_RESP} dlb_fsm_t;

  typedef struct packed {
    logic              valid;
    logic              write;
    logic              instr;
    logic [31:0]       addr;
    logic [WORD_W-1:0] wdata;
    logic [3:0]        wstrb;
  } dlb_cpu_req_t;

  typedef struct packed {
    logic        valid;
    logic [31:0] addr;
  } dlb_rd_req_t;

  typedef struct packed {
    logic              valid;
    logic [31:0]       addr;
    logic [LINE_W-1:0] data;
    logic [BE_W-1:0]   strb;
  } dlb_wr_req_t;

  typedef struct packed {
    logic [TAG_W-1:0]    tag;
    dlb_line_state_tag_t st;
    logic [LINE_W-1:0]   data;
    logic [BE_W-1:0]     be;
    logic [1:0]          stamp;
    logic [1:0]          recency_counter;
  } dlb_line_t;

  typedef struct packed {
    logic                 flush_aggressiveness;
    logic [NUM_LINES-1:0] line_en;
    logic [7:0]           age_div;
  } dlb_cfg_t;
endpackage

// >>> testbench/dlb_mem_model.sv
// Memory-side model for the line buffer read and write ports.
// Assumes one outstanding request; DELAY sets each wait in cycles.
`timescale 1ns/1ps
module dlb_mem_model
  import dlb_pkg::*;
(
  input  wire logic              CLOCK,
  input  wire logic              SYS_RST,
  input  wire logic [3:0]        DELAY,
  input  wire dlb_rd_req_t       MEM_RD,
  input  wire dlb_wr_req_t       MEM_WR,
  output logic                   MEM_RD_READY,
  output logic                   MEM_RD_VALID,
  output logic [LINE_W-1:0]      MEM_RD_DATA,
  output logic                   MEM_WR_READY,
  output logic                   MEM_WR_RESP
);
  logic [LINE_W-1:0] mem [logic [TAG_W-1:0]];
  int                rd_count = 0;

  // Untouched lines hold their own word addresses
  function automatic logic [LINE_W-1:0] line_of(input logic [TAG_W-1:0] t);
    if (mem.exists(t))
      return mem[t];
    return {t, 4'hC, t, 4'h8, t, 4'h4, t, 4'h0};
  endfunction

  initial begin
    logic [31:0]       a;
    logic [LINE_W-1:0] d;
    logic [LINE_W-1:0] o;
    logic [BE_W-1:0]   s;
    {MEM_RD_READY, MEM_RD_VALID, MEM_WR_READY, MEM_WR_RESP} = 4'h0;
    MEM_RD_DATA = '1;
    forever begin
      @(posedge CLOCK);
      if (!SYS_RST && MEM_RD.valid) begin
        repeat (DELAY) @(posedge CLOCK);
        a = MEM_RD.addr;
        MEM_RD_READY <= 1'b1;
        @(posedge CLOCK);
        MEM_RD_READY <= 1'b0;
        rd_count++;
        repeat (DELAY) @(posedge CLOCK);
        d = line_of(a[31:4]);
        MEM_RD_VALID <= 1'b1;
        MEM_RD_DATA  <= d;
        @(posedge CLOCK);
        MEM_RD_VALID <= 1'b0;
        // Stale beat inverted so it never passes for fresh data
        MEM_RD_DATA  <= ~d;
      end else if (!SYS_RST && MEM_WR.valid) begin
        repeat (DELAY) @(posedge CLOCK);
        {a, d, s} = {MEM_WR.addr, MEM_WR.data, MEM_WR.strb};
        MEM_WR_READY <= 1'b1;
        @(posedge CLOCK);
        MEM_WR_READY <= 1'b0;
        o = line_of(a[31:4]);
        for (int i = 0; i < BE_W; i++)
          if (s[i]) o[i*8 +: 8] = d[i*8 +: 8];
        mem[a[31:4]] = o;
        repeat (DELAY) @(posedge CLOCK);
        MEM_WR_RESP <= 1'b1;
        @(posedge CLOCK);
        MEM_WR_RESP <= 1'b0;
      end
    end
  end
endmodule

// >>> testbench/tb_top.sv
// Self-checking bench: directed and random CPU traffic against a shadow memory.
// Assumes dlb_mem_model on the memory ports; its store is compared at the end.
`timescale 1ns/1ps
module tb_top;
  import dlb_pkg::*;
  logic              clock = 1'b0;
  logic              sys_rst;
  dlb_cfg_t          cfg;
  logic              sleep_req;
  logic              flush_req;
  logic              inval_req;
  dlb_cpu_req_t      cpu_req;
  logic              cpu_bypass;
  logic              cpu_done;
  logic [WORD_W-1:0] cpu_rdata;
  dlb_rd_req_t       mem_rd;
  dlb_wr_req_t       mem_wr;
  logic              rd_ready;
  logic              rd_valid;
  logic [LINE_W-1:0] rd_data;
  logic              wr_ready;
  logic              wr_resp;
  logic              busy;
  logic [2:0]        dirty_lines;
  logic [3:0]        mem_dly;
  logic [31:0]       seed = 32'h0000_2E35;
  logic [LINE_W-1:0] shadow [logic [TAG_W-1:0]];
  logic [WORD_W-1:0] exp_q [$];
  logic [TAG_W-1:0]  tags [8] = '{28'h1006000, 28'h1006001, 28'h1006002, 28'h1006003,
                                 28'h1006004, 28'h1006005, 28'h10A0000, 28'h1FFFFFF};
  logic [32:0]       byp [4] = '{{1'b0, 32'h1005_FFFC}, {1'b0, 32'h2000_0000},
                                 {1'b1, 32'h1006_0000}, {1'b0, 32'h0000_1000}};
  dlb_cfg_t          phases [4] = '{'{1'b0, 4'h1, 8'h02}, '{1'b0, 4'hF, 8'h01},
                                    '{1'b1, 4'hF, 8'h03}, '{1'b0, 4'h5, 8'hFF}};
  int                failures = 0;
  int                samples_checked = 0;
  int                wait_n;
  int                n0;

  dlb_data_line_buffer_unit u_dut (
    .CLOCK(clock), .SYS_RST(sys_rst), .CFG(cfg), .SLEEP_REQ(sleep_req),
    .FLUSH_REQ(flush_req), .INVAL_REQ(inval_req), .CPU_REQ(cpu_req),
    .CPU_BYPASS(cpu_bypass), .CPU_DONE(cpu_done), .CPU_RDATA(cpu_rdata),
    .MEM_RD(mem_rd), .MEM_RD_READY(rd_ready), .MEM_RD_VALID(rd_valid),
    .MEM_RD_DATA(rd_data), .MEM_WR(mem_wr), .MEM_WR_READY(wr_ready),
    .MEM_WR_RESP(wr_resp), .BUSY(busy), .DIRTY_LINES(dirty_lines)
  );
  dlb_mem_model u_mem (
    .CLOCK(clock), .SYS_RST(sys_rst), .DELAY(mem_dly), .MEM_RD(mem_rd),
    .MEM_WR(mem_wr), .MEM_RD_READY(rd_ready), .MEM_RD_VALID(rd_valid),
    .MEM_RD_DATA(rd_data), .MEM_WR_READY(wr_ready), .MEM_WR_RESP(wr_resp)
  );

  always #5 clock = ~clock;

  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [LINE_W-1:0] cur(input logic [TAG_W-1:0] t);
    if (shadow.exists(t))
      return shadow[t];
    return {t, 4'hC, t, 4'h8, t, 4'h4, t, 4'h0};
  endfunction

  task automatic check(input logic [LINE_W-1:0] got, input logic [LINE_W-1:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("checked=%0d failures=%0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic hung();
    check(1'b0, 1'b1);
    tally_and_finish();
  endtask

  // Request stays up after done so back-to-back calls need no gap
  task automatic cpu_op(input logic wr, input logic [31:0] a, input logic [31:0] d,
                        input logic [3:0] s);
    logic [LINE_W-1:0] l;
    int                b;
    l = cur(a[31:4]);
    b = a[3:2] * 32;
    if (wr) begin
      for (int i = 0; i < WORD_BY; i++)
        if (s[i]) l[b+i*8 +: 8] = d[i*8 +: 8];
      shadow[a[31:4]] = l;
    end else
      exp_q.push_back(l[b +: 32]);
    mem_dly <= 4'(rnd() % 4);
    cpu_req <= '{1'b1, wr, 1'b0, a, d, s};
    wait_n = 0;
    do begin
      @(posedge clock);
      if (++wait_n > 600) hung();
    end while (cpu_done !== 1'b1);
  endtask

  task automatic quiet(input int n);
    cpu_req.valid <= 1'b0;
    repeat (n) @(posedge clock);
  endtask

  task automatic pulse_wait(input int k);
    cpu_req.valid <= 1'b0;
    flush_req <= (k == 0);
    sleep_req <= (k == 1);
    inval_req <= (k == 2);
    @(posedge clock);
    {flush_req, sleep_req, inval_req} <= 3'h0;
    repeat (2) @(posedge clock);
    wait_n = 0;
    while (busy !== 1'b0) begin
      @(posedge clock);
      if (++wait_n > 600) hung();
    end
  endtask

  task automatic barrier();
    pulse_wait(0);
    check(dirty_lines, 3'h0);
    pulse_wait(2);
  endtask

  always @(posedge clock) begin
    if (cpu_done === 1'b1 && cpu_req.write === 1'b0) begin
      if (exp_q.size() == 0)
        check(1'b1, 1'b0);
      else
        check(cpu_rdata, exp_q.pop_front());
    end
    if (cpu_req.valid && !cpu_req.instr && cpu_req.addr >= WIN_LO && cpu_req.addr <= WIN_HI)
      check(cpu_bypass, 1'b0);
    // Unknown count must trip as well
    if (sys_rst === 1'b0 && (dirty_lines <= 3'($countones(cfg.line_en))) !== 1'b1)
      check(dirty_lines, 3'h0);
  end

  initial begin
    sys_rst = 1'b1;
    cfg = '{1'b1, 4'hF, 8'hFF};
    {sleep_req, flush_req, inval_req} = 3'h0;
    cpu_req = '0;
    mem_dly = 4'h0;
    repeat (3) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
    check(dirty_lines, 3'h0);
    foreach (byp[i]) begin
      cpu_req <= '{1'b1, 1'(rnd()), byp[i][32], byp[i][31:0], rnd(), 4'hF};
      n0 = 0;
      repeat (8) begin
        @(negedge clock);
        n0 += (cpu_done !== 1'b0);
      end
      check(cpu_bypass, 1'b1);
      check(n0, 0);
      @(posedge clock);
    end
    barrier();
    n0 = u_mem.rd_count;
    cpu_op(0, {tags[0], 4'h0}, 0, 0);
    cpu_op(0, {tags[0], 4'hC}, 0, 0);
    check(u_mem.rd_count - n0, 1);
    cpu_op(1, {tags[0], 4'h4}, rnd(), 4'h9);
    cpu_op(0, {tags[0], 4'h4}, 0, 0);
    check(dirty_lines, 3'h1);
    for (int w = 0; w < 4; w++)
      cpu_op(1, {tags[1], 2'(w), 2'h0}, rnd(), 4'hF);
    cpu_op(0, {tags[1], 4'h8}, 0, 0);
    check(u_mem.rd_count - n0, 1);
    cpu_op(1, {tags[2], 4'h4}, rnd(), 4'h6);
    check(dirty_lines, 3'h3);
    cpu_op(0, {tags[2], 4'h4}, 0, 0);
    cpu_op(0, {tags[2], 4'h0}, 0, 0);
    check(u_mem.rd_count - n0, 2);
    // Flushed modified lines stay readable until invalidated
    pulse_wait(0);
    check(dirty_lines, 3'h0);
    cpu_op(0, {tags[1], 4'h8}, 0, 0);
    check(u_mem.rd_count - n0, 2);
    pulse_wait(2);
    cpu_op(0, {tags[0], 4'h4}, 0, 0);
    check(u_mem.rd_count - n0, 3);
    for (int f = 0; f < 2; f++) begin
      barrier();
      cfg <= '{1'(f), 4'hF, 8'hFF};
      for (int i = 0; i < 4; i++)
        cpu_op(1, {tags[i], 4'h0}, rnd(), 4'h3);
      quiet(40);
      check(dirty_lines, 3'(2 + f));
    end
    pulse_wait(1);
    check(dirty_lines, 3'h0);
    cfg <= '{1'b0, 4'hF, 8'h14};
    quiet(300);
    cpu_op(1, {tags[3], 4'h8}, rnd(), 4'h2);
    quiet(15);
    check(dirty_lines, 3'h1);
    quiet(65);
    check(dirty_lines, 3'h0);
    // Single-line setup runs first
    for (int p = 0; p < 4; p++) begin
      barrier();
      cfg <= phases[p];
      for (int i = 0; i < 150; i++)
        cpu_op(1'(rnd()), {tags[rnd() % 8], 2'(rnd()), 2'h0}, rnd(), 4'(rnd()) | 4'h1);
    end
    barrier();
    for (int i = 0; i < 8; i++)
      check(u_mem.line_of(tags[i]), cur(tags[i]));
    check(exp_q.size(), 0);
    tally_and_finish();
  end
endmodule
